/* rtl/kbsip_port.sv */
// keyboard strobe input port: data latch, request latch, status port, port decode
// assumes bus signals are on ref_clk; keyboard pins are asynchronous
`timescale 1ns/1ns
module kbsip_port
  import kbsip_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // keyboard pins
  input  wire logic [KBSIP_DATA_W-1:0] kbd_data,
  input  wire logic                    kbd_strobe,
  // jumpers and switches
  input  wire logic                    strobe_polarity_jumper,
  input  wire logic [KBSIP_SEL_W-1:0]  port_addr_switch,
  input  wire logic [KBSIP_PRI_W-1:0]  interrupt_priority_jumper,
  // processor input-port bus
  input  wire logic                    io_rd,
  input  wire logic                    irq_ack,
  input  wire logic [KBSIP_ADDR_W-1:0] io_addr,
  output logic      [KBSIP_DATA_W-1:0] io_rdata,
  output logic                         io_rdata_en,
  // interrupt request
  output logic                         irq,
  output logic      [KBSIP_PRI_W-1:0]  irq_level
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [KBSIP_DATA_W:0] pins_sync;

  kbsip_sync #(.W(KBSIP_DATA_W + 1)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     ({kbd_strobe, kbd_data}),
    .dout    (pins_sync)
  );

  logic                    strobe_raw;
  logic [KBSIP_DATA_W-1:0] data_sync;
  assign strobe_raw = pins_sync[KBSIP_DATA_W];
  assign data_sync  = pins_sync[KBSIP_DATA_W-1:0];

  // ****************************************
  // strobe edge detect
  // ****************************************
  logic strobe_act;
  logic strobe_prev;
  logic next_strobe_prev;
  logic key_edge;

  assign strobe_act = strobe_raw ^ strobe_polarity_jumper;
  assign key_edge   = strobe_act & ~strobe_prev;

  // ****************************************
  // port decode
  // ****************************************
  function automatic kbsip_sel_t decode(input logic [KBSIP_ADDR_W-1:0] a,
                                        input logic [KBSIP_SEL_W-1:0]  sw);
    if (a[KBSIP_ADDR_W-1 -: KBSIP_SEL_W] != sw) begin
      return KBSIP_SEL_NONE;
    end
    // low bits only pick data or status; the port itself ignores them
    if (a[1:0] == KBSIP_STATUS_IDX) begin
      return KBSIP_SEL_STATUS;
    end
    return KBSIP_SEL_DATA;
  endfunction : decode

  kbsip_sel_t sel;
  assign sel = io_rd ? decode(io_addr, port_addr_switch) : KBSIP_SEL_NONE;

  // ****************************************
  // latches
  // ****************************************
  logic [KBSIP_DATA_W-1:0] data_latch;
  logic [KBSIP_DATA_W-1:0] next_data_latch;
  logic                    req_latch;
  logic                    next_req_latch;
  logic [KBSIP_DATA_W-1:0] next_io_rdata;
  logic                    next_io_rdata_en;

  always_comb begin
    next_strobe_prev = strobe_act;
    next_data_latch  = data_latch;
    next_req_latch   = req_latch;
    if (key_edge) begin
      next_data_latch = data_sync;
    end
    // a data read or an acknowledge services the key; a new edge wins the tie
    if ((sel == KBSIP_SEL_DATA) || irq_ack) begin
      next_req_latch = 1'b0;
    end
    if (key_edge) begin
      next_req_latch = 1'b1;
    end
    next_io_rdata    = '0;
    next_io_rdata_en = 1'b0;
    case (sel)
      KBSIP_SEL_DATA: begin
        next_io_rdata    = data_latch;
        next_io_rdata_en = 1'b1;
      end
      KBSIP_SEL_STATUS: begin
        next_io_rdata[KBSIP_STAT_REQ_BIT] = req_latch;
        next_io_rdata[KBSIP_STAT_STB_BIT] = strobe_raw;
        next_io_rdata_en                  = 1'b1;
      end
      default: begin
        next_io_rdata_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // prev starts active: the synchroniser reads zero for two edges after reset,
      // which with the inverted jumper would otherwise look like a fresh keypress
      strobe_prev <= 1'b1;
      data_latch  <= KBSIP_DATA_RST;
      req_latch   <= 1'b0;
      io_rdata    <= '0;
      io_rdata_en <= 1'b0;
    end else begin
      strobe_prev <= next_strobe_prev;
      data_latch  <= next_data_latch;
      req_latch   <= next_req_latch;
      io_rdata    <= next_io_rdata;
      io_rdata_en <= next_io_rdata_en;
    end
  end

  assign irq       = req_latch;
  assign irq_level = interrupt_priority_jumper;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_key_edge;
    key_edge;
  endsequence

  sequence s_data_read;
    sel == KBSIP_SEL_DATA;
  endsequence

  a_edge_sets_req: assert property (@(posedge ref_clk) disable iff (rst)
    s_key_edge |=> irq)
    else $error("strobe edge did not raise irq");

  a_edge_loads_data: assert property (@(posedge ref_clk) disable iff (rst)
    key_edge |=> data_latch == $past(data_sync))
    else $error("data latch not loaded on edge");

  a_data_held: assert property (@(posedge ref_clk) disable iff (rst)
    !key_edge |=> $stable(data_latch))
    else $error("data latch changed without edge");

  a_data_read_out: assert property (@(posedge ref_clk) disable iff (rst)
    s_data_read |=> io_rdata_en && io_rdata == $past(data_latch))
    else $error("data read returned wrong byte");

  a_status_req_bit: assert property (@(posedge ref_clk) disable iff (rst)
    sel == KBSIP_SEL_STATUS |=> io_rdata[KBSIP_STAT_REQ_BIT] == $past(irq))
    else $error("status bit zero wrong");

  a_status_stb_bit: assert property (@(posedge ref_clk) disable iff (rst)
    sel == KBSIP_SEL_STATUS |=> io_rdata[KBSIP_STAT_STB_BIT] == $past(strobe_raw))
    else $error("status bit seven wrong");

  a_polarity_edge: assert property (@(posedge ref_clk) disable iff (rst)
    key_edge |-> (strobe_raw != strobe_polarity_jumper) && (strobe_prev == 1'b0))
    else $error("edge seen at wrong polarity");

  a_decode_miss: assert property (@(posedge ref_clk) disable iff (rst)
    (io_addr[KBSIP_ADDR_W-1 -: KBSIP_SEL_W] != port_addr_switch) |=> !io_rdata_en)
    else $error("answered a foreign port");

  a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    irq |-> irq_level == interrupt_priority_jumper)
    else $error("irq level not from jumper");

  // ****************************************
  // request latch, reset, idle-bus and status spare-bit checks
  // ****************************************
  sequence s_service;
    (sel == KBSIP_SEL_DATA) || irq_ack;
  endsequence

  a_service_clears: assert property (@(posedge ref_clk) disable iff (rst)
    s_service ##0 !key_edge |=> !irq)
    else $error("serviced request still raised");

  a_edge_wins_clear: assert property (@(posedge ref_clk) disable iff (rst)
    s_service ##0 s_key_edge |=> irq)
    else $error("clear beat a new keypress");

  a_req_holds: assert property (@(posedge ref_clk) disable iff (rst)
    !key_edge && (sel != KBSIP_SEL_DATA) && !irq_ack |=> irq == $past(irq))
    else $error("request changed without cause");

  a_reset_no_edge: assert property (@(posedge ref_clk)
    rst ##1 !rst |-> !key_edge ##1 !key_edge)
    else $error("false keypress after reset");

  a_idle_bus_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    !io_rd |=> !io_rdata_en && (io_rdata == '0))
    else $error("bus driven without a read");

  a_status_spare_bits: assert property (@(posedge ref_clk) disable iff (rst)
    sel == KBSIP_SEL_STATUS |=> io_rdata[KBSIP_STAT_STB_BIT-1:KBSIP_STAT_REQ_BIT+1] == '0)
    else $error("status spare bits not zero");

endmodule : kbsip_port

/* rtl/kbsip_pkg.sv */
// package for the keyboard strobe input port: constants, field positions, port map
// assumes one clock domain (ref_clk, 125 MHz) and a synchronous active-high reset
package kbsip_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int KBSIP_DATA_W = 8;
  localparam int KBSIP_ADDR_W = 8;
  localparam int KBSIP_SEL_W  = 6;
  localparam int KBSIP_PRI_W  = 3;

  // ****************************************
  // port map (low two address bits choose the register)
  // ****************************************
  localparam logic [1:0] KBSIP_DATA_IDX   = 2'h0;
  localparam logic [1:0] KBSIP_STATUS_IDX = 2'h1;

  // ****************************************
  // status field positions
  // ****************************************
  localparam int KBSIP_STAT_REQ_BIT = 0;
  localparam int KBSIP_STAT_STB_BIT = 7;

  // ****************************************
  // reset and default values
  // ****************************************
  localparam logic [KBSIP_DATA_W-1:0] KBSIP_DATA_RST    = 8'h00;
  localparam logic [KBSIP_SEL_W-1:0]  KBSIP_SEL_DEFAULT = 6'h3e;
  localparam logic [KBSIP_PRI_W-1:0]  KBSIP_PRI_DEFAULT = 3'h2;

  typedef enum logic [1:0] {
    KBSIP_SEL_NONE,
    KBSIP_SEL_DATA,
    KBSIP_SEL_STATUS
  } kbsip_sel_t;

endpackage : kbsip_pkg

/* rtl/kbsip_sync.sv */
// two-flop synchroniser for asynchronous keyboard pins
// assumes the pins are quasi-static around each strobe edge
`timescale 1ns/1ns
module kbsip_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // async in, synced out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end

endmodule : kbsip_sync

/* bench/kbsip_kbd_model.sv */
// keyboard model: eight data lines and a keypress strobe
// assumes go is raised for one cycle per key, and only while busy is low
`timescale 1ns/1ns
module kbsip_kbd_model
  import kbsip_pkg::*;
(
  // clock and strobe sense
  input  wire logic                    ref_clk,
  input  wire logic                    polarity,
  // key request
  input  wire logic                    go,
  input  wire logic [KBSIP_DATA_W-1:0] key,
  output logic                         busy,
  // keyboard pins
  output logic      [KBSIP_DATA_W-1:0] kbd_data,
  output logic                         kbd_strobe
);
  logic active;

  // strobe idles at the jumper level
  assign kbd_strobe = polarity ^ active;

  initial begin
    busy     = 1'b0;
    active   = 1'b0;
    kbd_data = 8'h00a5;
  end

  always begin
    @(posedge ref_clk iff go);
    busy     = 1'b1;
    kbd_data = key;
    repeat (2) @(negedge ref_clk);
    active = 1'b1;
    repeat (4) @(negedge ref_clk);
    active = 1'b0;
    repeat (4) @(negedge ref_clk);
    // hold time over: show something other than the last byte
    kbd_data = ~key;
    busy     = 1'b0;
  end
endmodule : kbsip_kbd_model

/* bench/testbench.sv */
// self-checking bench for the keyboard strobe input port
// assumes the keyboard model above and static jumpers changed only under reset
`timescale 1ns/1ns
module testbench;
  import kbsip_pkg::*;
  logic       ref_clk = 1'b0, rst = 1'b1, pol = 1'b0, go = 1'b0;
  logic       io_rd = 1'b0, irq_ack = 1'b0, io_rdata_en, irq, busy, stb, en;
  logic [7:0] io_addr = 8'h0000, io_rdata, key = 8'h0000, kdat, d;
  logic [5:0] sw = KBSIP_SEL_DEFAULT;
  logic [2:0] pri = KBSIP_PRI_DEFAULT, irq_level;
  logic [31:0] seed = 32'hd5e1_eef4;
  int         n_errors = 0, total_checks = 0;

  always #4 ref_clk = ~ref_clk;

  kbsip_kbd_model kbd (.ref_clk(ref_clk), .polarity(pol), .go(go), .key(key), .busy(busy),
                       .kbd_data(kdat), .kbd_strobe(stb));
  kbsip_port dut (.ref_clk(ref_clk), .rst(rst), .kbd_data(kdat), .kbd_strobe(stb),
                  .strobe_polarity_jumper(pol), .port_addr_switch(sw),
                  .interrupt_priority_jumper(pri), .io_rd(io_rd), .irq_ack(irq_ack),
                  .io_addr(io_addr), .io_rdata(io_rdata), .io_rdata_en(io_rdata_en),
                  .irq(irq), .irq_level(irq_level));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] exp_stat(input logic p, input logic req);
    return {p, 6'h00, req};
  endfunction : exp_stat

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // one-cycle read pulse; the answer may land one or two edges later
  task automatic rd(input logic [7:0] a);
    d = 8'h0000;
    en = 1'b0;
    @(negedge ref_clk);
    io_rd = 1'b1;
    io_addr = a;
    @(negedge ref_clk);
    io_rd = 1'b0;
    repeat (2) begin
      if (io_rdata_en === 1'b1 && !en) begin
        en = 1'b1;
        d = io_rdata;
      end
      @(negedge ref_clk);
    end
  endtask : rd

  task automatic press(input logic [7:0] k);
    int n;
    @(negedge ref_clk);
    go = 1'b1;
    key = k;
    @(negedge ref_clk);
    go = 1'b0;
    for (n = 0; n < 50 && busy; n++) @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
  endtask : press

  task automatic do_reset(input logic p);
    @(negedge ref_clk);
    rst = 1'b1;
    pol = p;
    seed = lfsr(seed);
    sw = seed[5:0];
    pri = seed[10:8];
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask : do_reset

  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [7:0] k;
    for (int p = 0; p < 2; p++) begin
      do_reset(p[0]);
      chk1(irq, 1'b0);
      chk8({5'h00, irq_level}, {5'h00, pri});
      for (int i = 0; i < 6; i++) begin
        seed = lfsr(seed);
        k = (i == 0) ? 8'h0080 : seed[7:0];
        press(k);
        chk1(irq, 1'b1);
        rd({sw, 2'h1});
        chk8(d, exp_stat(p[0], 1'b1));
        rd({sw, 2'h1} ^ 8'h0004);
        chk1(en, 1'b0);
        rd({sw, 2'(seed[9:8] | {seed[8], 1'b0})});
        chk8(d, k);
        chk1(irq, 1'b0);
        rd({sw, 2'h1});
        chk8(d, exp_stat(p[0], 1'b0));
      end
      $display("test polarity %0d done", p);
    end
    // second key overwrites, then acknowledge clears the request
    press(8'h0011);
    press(8'h00ee);
    rd({sw, 2'h0});
    chk8(d, 8'h00ee);
    press(8'h0033);
    @(negedge ref_clk);
    irq_ack = 1'b1;
    @(negedge ref_clk);
    irq_ack = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk1(irq, 1'b0);
    $display("test overwrite and ack done");
    complete_run();
  end

  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule : testbench
